// *** tb/cod_assertions.sv ***
`timescale 1ns/1ns
module cod_assertions
  import cod_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic req,
  input wire logic wr,
  input wire logic [1:0] space,
  input wire logic [15:0] addr,
  input wire logic [4:0] offs,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic nak,
  input wire logic [7:0] rdata
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Diagnostic record read decode, record and object-index paths
  wire rd_diag = !wr && ((space == SP_REC && addr == REC_DIAG) ||
                         (space == SP_IDX && addr == OI_DIAG));
  // A taken request and its single answer
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_answer;
    ack ##1 (!ack && !req);
  endsequence
  property p_answer; s_take |=> s_answer; endproperty
  a_answer: assert property (p_answer)
    else $error("link answer missing or not single");
  property p_hold; s_take |=> $stable({wr, space, addr, offs, wdata}); endproperty
  a_hold: assert property (p_hold)
    else $error("request fields moved while pending");
  property p_idle; !req |=> !ack; endproperty
  a_idle: assert property (p_idle)
    else $error("answer without request");
  property p_diag_ro;
    s_take and (wr && space == SP_REC && addr == REC_DIAG) |=> ack && nak;
  endproperty
  a_diag_ro: assert property (p_diag_ro)
    else $error("diagnostic write not refused");
  property p_head_len;
    s_take and (!wr && space == SP_IDX && addr == OI_DIAG_HEAD && offs >= DIAG_HEAD) |=> nak;
  endproperty
  a_head_len: assert property (p_head_len)
    else $error("head read beyond four bytes accepted");
  property p_modinfo;
    s_take and (rd_diag && offs == DG_MODINFO) |=> !nak && rdata == 8'h15;
  endproperty
  a_modinfo: assert property (p_modinfo)
    else $error("module info byte wrong");
  property p_chkind; s_take and (rd_diag && offs == DG_CHKIND) |=> rdata == 8'h73; endproperty
  a_chkind: assert property (p_chkind)
    else $error("channel kind byte wrong");
  property p_nch; s_take and (rd_diag && offs == DG_NCH) |=> rdata == 8'h04; endproperty
  a_nch: assert property (p_nch)
    else $error("channel count byte wrong");
  property p_rsvd; s_take and (rd_diag && offs inside {[12:15]}) |=> rdata == 8'h00; endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved channel byte not zero");
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  import cod_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic cw = 1'b0;
  logic [1:0] csp = 2'h0;
  logic [15:0] cad = 16'h0000;
  logic [4:0] cof = 5'h00;
  logic [7:0] cwd = 8'h00;
  logic busy, done, fail, mled;
  logic [7:0] rdat;
  logic [3:0][15:0] code = 64'h0;
  logic [3:0][15:0] ua;
  logic [3:0] wopen = 4'h0;
  logic [3:0] on, eled;
  logic aux = 1'b0;
  int num_errors = 0;
  int total_checks = 0;
  // Clock, link and the two ends
  always #10 clk = ~clk;
  cod_link_if lk();
  cod_device u_cod_device(.CLK(clk), .RST(rst), .LK(lk.dev), .OUT_CODE(code),
    .WIRE_OPEN(wopen), .AUX_MISSING(aux), .CH_UA(ua), .CH_ON(on), .CH_ERR_LED(eled),
    .MOD_ERR_LED(mled));
  cod_host u_cod_host(.CLK(clk), .RST(rst), .LK(lk.host), .CMD_GO(go), .CMD_WR(cw),
    .CMD_SPACE(csp), .CMD_ADDR(cad), .CMD_OFFS(cof), .CMD_WDATA(cwd), .CMD_BUSY(busy),
    .CMD_DONE(done), .CMD_FAIL(fail), .CMD_RDATA(rdat));
  cod_assertions u_cod_assertions(.CLK(clk), .RST(rst), .req(lk.req), .wr(lk.wr),
    .space(lk.space), .addr(lk.addr), .offs(lk.offs), .wdata(lk.wdata), .ack(lk.ack),
    .nak(lk.nak), .rdata(lk.rdata));
  // Verdict
  task end_sim;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One host command, waits for its completion
  task automatic cmd(input logic w, input logic [1:0] s, input logic [15:0] a,
    input logic [4:0] o, input logic [7:0] d);
    int n;
    @(posedge clk);
    go <= 1'b1;
    cw <= w;
    csp <= s;
    cad <= a;
    cof <= o;
    cwd <= d;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n == 1) `CHK(busy, 1'b1)
    end while (done !== 1'b1 && n < 8);
    `CHK({done, busy}, 2'b10)
  endtask
  // Read one byte and compare it
  task automatic rdc(input logic [1:0] s, input logic [15:0] a, input logic [4:0] o,
    input logic [7:0] e);
    cmd(1'b0, s, a, o, 8'h00);
    `CHK({fail, rdat}, {1'b0, e})
  endtask
  // Reset contents of both records
  task automatic t_defaults;
    logic [63:0] ed = 64'h0004_0873_0000_1500;
    for (int i = 0; i < 8; i++) begin
      rdc(SP_REC, REC_DIAG, 5'(i), ed[8*i +: 8]);
    end
    for (int i = 0; i < 4; i++) begin
      rdc(SP_REC, REC_FN0 + 16'(i), 5'h00, 8'h31);
    end
    rdc(SP_IDX, OI_PAR0 + 16'h0001, 5'h00, 8'h00);
    rdc(SP_SUB, OS_PAR0, 5'h00, 8'h00);
    `CHK(on, 4'hF)
  endtask
  // Refused transfers and the communication flag
  task automatic t_refuse;
    cmd(1'b1, SP_REC, REC_DIAG, 5'h00, 8'hFF);
    `CHK(fail, 1'b1)
    rdc(SP_REC, REC_HEAD, 5'h00, 8'h03);
    cmd(1'b0, SP_IDX, OI_DIAG_HEAD, 5'h04, 8'h00);
    `CHK(fail, 1'b1)
    rdc(SP_IDX, OI_DIAG_HEAD, 5'h03, 8'h10);
    rdc(SP_IDX, OI_DIAG, 5'h03, 8'h00);
  endtask
  // Every range function; 30h, 31h, 40h and 41h over all three parameter paths, FFh by index only
  task automatic t_range;
    int c;
    logic [39:0] tv [14] = '{40'h31_6C00_4E20, 40'h31_7FFF_5BDD, 40'h31_FFFB_0000,
      40'h41_4000_4E20, 40'h41_7FFF_61A8, 40'h41_8000_0000, 40'h30_0000_0FA0,
      40'h30_3600_2EE0, 40'h30_E500_0000, 40'h30_8000_0000, 40'h40_2000_2EE0,
      40'h40_5000_5DC0, 40'h40_F000_0000, 40'hFF_4000_0000};
    for (int i = 0; i < 14; i++) begin
      c = i % 4;
      @(posedge clk);
      code[c] <= tv[i][31:16];
      case (i % 3)
        0: cmd(1'b1, SP_REC, REC_FN0 + 16'(c), 5'h00, tv[i][39:32]);
        1: cmd(1'b1, SP_IDX, OI_PAR0 + 16'(c + 2), 5'h00, tv[i][39:32]);
        default: cmd(1'b1, SP_SUB, OS_PAR0 + 16'(c + 2), 5'h00, tv[i][39:32]);
      endcase
      repeat (2) @(posedge clk);
      #1;
      `CHK(ua[c], tv[i][15:0])
      `CHK(on[c], tv[i][39:32] != 8'hFF)
    end
  endtask
  // Parameter fault, wire break, supply loss and timestamp
  task automatic t_fault;
    logic [7:0] ts;
    cmd(1'b1, SP_REC, REC_FN0 + 16'h0001, 5'h00, 8'h55);
    rdc(SP_IDX, OI_PAR0 + 16'h0003, 5'h00, 8'h55);
    rdc(SP_REC, REC_DIAG, DG_CH0 + 5'h01, 8'h01);
    rdc(SP_REC, REC_DIAG, DG_CHSUM, 8'h02);
    rdc(SP_REC, REC_DIAG, DG_MODFLAG, 8'h89);
    `CHK({mled, eled}, 5'h12)
    cmd(1'b1, SP_IDX, OI_PAR0 + 16'h0003, 5'h00, 8'h31);
    @(posedge clk);
    // Break probed only on a live-zero channel held well above 100 codes
    wopen <= 4'h4;
    rdc(SP_REC, REC_DIAG, DG_CH0 + 5'h02, 8'h00);
    cmd(1'b1, SP_REC, REC_HEAD, 5'h01, 8'hF4);
    rdc(SP_SUB, OS_PAR0 + 16'h0001, 5'h00, 8'h04);
    rdc(SP_REC, REC_DIAG, DG_CH0 + 5'h02, 8'h10);
    @(posedge clk);
    aux <= 1'b1;
    rdc(SP_REC, REC_DIAG, DG_MODFLAG, 8'h1D);
    `CHK({mled, eled}, 5'h14)
    rdc(SP_IDX, OI_DIAG, DG_CH0 + 5'h04, 8'h00);
    cmd(1'b0, SP_IDX, OI_DIAG, DG_TS0, 8'h00);
    ts = rdat;
    cmd(1'b0, SP_IDX, OI_DIAG, DG_TS0 + 5'h01, 8'h00);
    `CHK({rdat, ts} != 16'h0000, 1'b1)
    rdc(SP_REC, REC_DIAG, DG_TS3, 8'h00);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_refuse();
    t_range();
    t_fault();
    end_sim();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end
endmodule

// *** verilog/cod_device.sv ***
`timescale 1ns/1ns
// Function
// RULE1: Six parameter bytes, defaults 00h 00h 31h.
// RULE2: Enable bits 0-3 arm wire-break per channel.
// RULE3: Range byte FFh switches channel off.
// RULE4: 31h maps 27648 to 20 mA.
// RULE5: 41h maps 16384 to 20 mA.
// RULE6: Negative codes give 0 mA in 0-20.
// RULE7: 30h/40h live-zero 4 mA with underrange.
// RULE8: Host expects false breaks below 100 codes.
// RULE9: No interrupt; errors light LED and record.
// RULE10: Record parameter faults, enabled wire breaks.
// RULE11: Diagnostics via record 01h, head 00h.
// RULE12: Parameters via records 00h, 80h-83h, indices.
// RULE13: Description bytes read 15h 73h 08h 04h.
// RULE14: First diagnostic byte carries module flags.
// RULE15: Bit 7 flags parameterization error.
// RULE16: Module info class 0101b, bit 4 info.
// RULE17: Four channel error bytes, reserved, timestamp.
// RULE18: Channel byte bit0 parameter, bit4 break.
// RULE19: Summary bits 0-3 per channel group.
// RULE20: Fourth byte bit3 overflow, bit4 communication.
// RULE21: Wrapping microsecond counter stamps diagnostic events.
// RULE22: Unknown range byte is a parameter error.
module cod_device
  import cod_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  cod_link_if.dev LK,
  input wire logic [3:0][15:0] OUT_CODE,
  input wire logic [3:0] WIRE_OPEN,
  input wire logic AUX_MISSING,
  output logic [3:0][15:0] CH_UA,
  output logic [3:0] CH_ON,
  output logic [3:0] CH_ERR_LED,
  output logic MOD_ERR_LED
);
  // Parameter byte select: {hit, byte index}
  function automatic logic [3:0] param_sel(input logic [1:0] sp, input logic [15:0] a,
                                           input logic [4:0] o, input logic w);
    logic [3:0] r;
    r = 4'h0;
    case (sp)
      SP_REC: begin
        if (a == REC_HEAD && w && o < PAR_REC0_LEN) begin
          r = {1'b1, o[2:0]}; // RULE12
        end else if (a >= REC_FN0 && a <= REC_FN3 && o == 5'h00) begin
          r = {1'b1, 3'(a - REC_FN0) + PAR_FN0}; // RULE12
        end
      end
      SP_IDX: begin
        if (a >= OI_PAR0 && a <= OI_PAR_LAST && o == 5'h00) begin
          r = {1'b1, 3'(a - OI_PAR0)}; // RULE12
        end
      end
      SP_SUB: begin
        if (a >= OS_PAR0 && a <= OS_PAR_LAST && o == 5'h00) begin
          r = {1'b1, 3'(a - OS_PAR0)}; // RULE12
        end
      end
      default: r = 4'h0;
    endcase
    return r;
  endfunction
  // Diagnostic byte select, reads only: {hit, byte index}
  function automatic logic [5:0] diag_sel(input logic [1:0] sp, input logic [15:0] a,
                                          input logic [4:0] o, input logic w);
    logic [5:0] r;
    logic head;
    logic full;
    r = 6'h00;
    head = (sp == SP_REC && a == REC_HEAD) || (sp == SP_IDX && a == OI_DIAG_HEAD);
    full = (sp == SP_REC && a == REC_DIAG) || (sp == SP_IDX && a == OI_DIAG);
    if (!w && ((head && o < DIAG_HEAD) || (full && o < DIAG_BYTES))) begin
      r = {1'b1, o}; // RULE11
    end
    return r;
  endfunction
  // Range function legality
  function automatic logic fn_legal(input logic [7:0] fn);
    return fn == FN_020_A || fn == FN_020_B || fn == FN_420_A ||
           fn == FN_420_B || fn == FN_OFF; // RULE22
  endfunction
  // Output code to microamps, clamped to the range limits
  function automatic logic [15:0] to_ua(input logic [7:0] fn, input logic signed [15:0] c);
    int d;
    int v;
    d = int'(c);
    v = 0;
    case (fn)
      FN_020_A: begin
        d = (d < 0) ? 0 : (d > OVR_A) ? OVR_A : d; // RULE6
        v = d * UA_SPAN20 / SCALE_A; // RULE4
      end
      FN_020_B: begin
        d = (d < 0) ? 0 : (d > OVR_B) ? OVR_B : d; // RULE6
        v = d * UA_SPAN20 / SCALE_B; // RULE5
      end
      FN_420_A: begin
        d = (d < UND_A) ? UND_A : (d > OVR_A) ? OVR_A : d;
        v = d * UA_SPAN16 / SCALE_A + UA_LIVE_ZERO; // RULE7
      end
      FN_420_B: begin
        d = (d < UND_B) ? UND_B : (d > OVR_B) ? OVR_B : d;
        v = d * UA_SPAN16 / SCALE_B + UA_LIVE_ZERO; // RULE7
      end
      default: v = 0; // RULE3
    endcase
    return v[15:0];
  endfunction
  logic [3:0] wbe_r;
  logic [3:0][7:0] fn_r;
  logic ack_r;
  logic nak_r;
  logic [7:0] rdata_r;
  logic comm_err_r;
  logic comm_err_nxt;
  logic [5:0] pre_r;
  logic [31:0] us_r;
  logic [31:0] stamp_r;
  logic [47:0] diag_prev_r;
  logic [3:0][15:0] ua_r;
  logic [3:0] on_r;
  logic [3:0] led_r;
  logic mod_led_r;
  logic take;
  logic [3:0] psel;
  logic [5:0] dsel;
  logic hit;
  logic [3:0] ch_on;
  logic [3:0] par_err;
  logic [3:0] wbrk;
  logic [3:0] ch_sum;
  logic [3:0][7:0] ch_err;
  logic [7:0] mod_flags;
  logic [7:0] int_flags;
  logic [7:0] pbyte;
  logic [7:0] dbyte;
  logic [47:0] diag_now;
  logic us_tick;
  // Link decode
  assign take = LK.req & ~ack_r;
  assign psel = param_sel(LK.space, LK.addr, LK.offs, LK.wr);
  assign dsel = diag_sel(LK.space, LK.addr, LK.offs, LK.wr);
  assign hit = psel[3] | dsel[5];
  // Per-channel status
  for (genvar i = 0; i < 4; i++) begin : g_ch
    assign ch_on[i] = fn_r[i] != FN_OFF; // RULE3
    assign par_err[i] = !fn_legal(fn_r[i]); // RULE22
    assign wbrk[i] = ch_on[i] & wbe_r[i] & WIRE_OPEN[i]; // RULE2 RULE10
    assign ch_sum[i] = |ch_err[i]; // RULE19
    always_comb begin
      ch_err[i] = 8'h00;
      ch_err[i][CE_PARAM] = par_err[i]; // RULE18
      ch_err[i][CE_WBRK] = wbrk[i]; // RULE18
    end
  end
  // Module level flags
  always_comb begin
    int_flags = 8'h00;
    int_flags[ED_OVF] = 1'b0; // RULE20
    int_flags[ED_COMM] = comm_err_r; // RULE20
    mod_flags = 8'h00;
    mod_flags[EA_INT] = |int_flags; // RULE14
    mod_flags[EA_EXT] = (|wbrk) | AUX_MISSING; // RULE14
    mod_flags[EA_CHAN] = |ch_sum; // RULE14
    mod_flags[EA_AUX] = AUX_MISSING; // RULE14
    mod_flags[EA_PARAM] = |par_err; // RULE15
    mod_flags[EA_FAIL] = mod_flags[EA_INT] | mod_flags[EA_EXT] | mod_flags[EA_CHAN] |
                         mod_flags[EA_PARAM];
  end

  // Parameter byte read mux, reserved bits read zero
  assign pbyte = (psel[2:0] == PAR_RSVD) ? 8'h00 :
                 (psel[2:0] == PAR_WBE) ? {4'h0, wbe_r} :
                 fn_r[2'(psel[2:0] - PAR_FN0)];

  // Diagnostic byte read mux
  always_comb begin
    dbyte = 8'h00;
    if (dsel[4:0] >= DG_CH0 && dsel[4:0] <= DG_CH3) begin
      dbyte = ch_err[2'(dsel[4:0] - DG_CH0)]; // RULE17
    end else if (dsel[4:0] >= DG_TS0 && dsel[4:0] <= DG_TS3) begin
      dbyte = stamp_r[8 * 2'(dsel[4:0] - DG_TS0) +: 8]; // RULE17
    end else begin
      case (dsel[4:0])
        DG_MODFLAG: dbyte = mod_flags; // RULE14
        DG_MODINFO: dbyte = MODINFO_VAL; // RULE13 RULE16
        DG_INTFLAG: dbyte = int_flags; // RULE20
        DG_CHKIND: dbyte = CHKIND_VAL; // RULE13
        DG_NBITS: dbyte = NBITS_VAL; // RULE13
        DG_NCH: dbyte = NCH_VAL; // RULE13
        DG_CHSUM: dbyte = {4'h0, ch_sum}; // RULE19
        default: dbyte = 8'h00;
      endcase
    end
  end

  // Refused request sets the communication flag; reading byte 3 clears, set wins
  assign comm_err_nxt = (take & ~hit) |
                        (comm_err_r & ~(take & dsel[5] & dsel[4:0] == DG_INTFLAG));

  // Link answer
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_r <= 1'b0;
      nak_r <= 1'b0;
      rdata_r <= 8'h00;
      comm_err_r <= 1'b0;
    end else begin
      ack_r <= take;
      nak_r <= take & ~hit;
      rdata_r <= (take & psel[3]) ? pbyte : (take & dsel[5]) ? dbyte : rdata_r;
      comm_err_r <= comm_err_nxt; // RULE20
    end
  end

  // Parameter writes
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wbe_r <= WBE_RST; // RULE1
      fn_r <= {4{FN_RST}}; // RULE1
    end else if (take & psel[3] & LK.wr) begin
      if (psel[2:0] == PAR_WBE) begin
        wbe_r <= LK.wdata[3:0]; // RULE2
      end else if (psel[2:0] >= PAR_FN0) begin
        fn_r[2'(psel[2:0] - PAR_FN0)] <= LK.wdata; // RULE1
      end
    end
  end

  // Microsecond ticker and event stamp
  assign us_tick = pre_r == US_CYC - 6'h01;
  assign diag_now = {mod_flags, int_flags, ch_err};
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pre_r <= 6'h00;
      us_r <= 32'h0000_0000;
      stamp_r <= 32'h0000_0000;
      diag_prev_r <= 48'h0000_0000_0000;
    end else begin
      pre_r <= us_tick ? 6'h00 : pre_r + 6'h01;
      us_r <= us_tick ? us_r + 32'h0000_0001 : us_r; // RULE21
      diag_prev_r <= diag_now;
      stamp_r <= (diag_now != diag_prev_r) ? us_r : stamp_r; // RULE21
    end
  end

  // Channel outputs and indicators; no interrupt output exists
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ua_r <= '0;
      on_r <= 4'h0;
      led_r <= 4'h0;
      mod_led_r <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        ua_r[i] <= to_ua(fn_r[i], OUT_CODE[i]); // RULE3 RULE4 RULE5 RULE7
      end
      on_r <= ch_on; // RULE3
      led_r <= ch_sum; // RULE9
      mod_led_r <= |mod_flags; // RULE9
    end
  end

  assign LK.ack = ack_r;
  assign LK.nak = nak_r;
  assign LK.rdata = rdata_r;
  assign CH_UA = ua_r;
  assign CH_ON = on_r;
  assign CH_ERR_LED = led_r;
  assign MOD_ERR_LED = mod_led_r;
endmodule

// *** verilog/cod_host.sv ***
`timescale 1ns/1ns
module cod_host
  import cod_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  cod_link_if.host LK,
  input wire logic CMD_GO,
  input wire logic CMD_WR,
  input wire logic [1:0] CMD_SPACE,
  input wire logic [15:0] CMD_ADDR,
  input wire logic [4:0] CMD_OFFS,
  input wire logic [7:0] CMD_WDATA,
  output logic CMD_BUSY,
  output logic CMD_DONE,
  output logic CMD_FAIL,
  output logic [7:0] CMD_RDATA
);

  cod_hstate_t state_r;
  cod_hstate_t state_nxt;
  logic req_r;
  logic wr_r;
  logic [1:0] space_r;
  logic [15:0] addr_r;
  logic [4:0] offs_r;
  logic [7:0] wdata_r;
  logic done_r;
  logic fail_r;
  logic [7:0] rdata_r;
  logic start;
  logic finish;

  // Sequencing
  assign start = (state_r == HS_IDLE) & CMD_GO;
  assign finish = (state_r == HS_WAIT) & LK.ack;
  always_comb begin
    case (state_r)
      HS_IDLE: state_nxt = CMD_GO ? HS_WAIT : HS_IDLE;
      HS_WAIT: state_nxt = LK.ack ? HS_IDLE : HS_WAIT;
      default: state_nxt = HS_IDLE;
    endcase
  end

  // Request held until the device answers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= HS_IDLE;
      req_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_r <= start | (req_r & ~LK.ack);
    end
  end

  // Command capture; addresses follow the shared record map
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_r <= 1'b0;
      space_r <= SP_REC;
      addr_r <= 16'h0000;
      offs_r <= 5'h00;
      wdata_r <= 8'h00;
    end else if (start) begin
      wr_r <= CMD_WR;
      space_r <= CMD_SPACE; // RULE11 RULE12
      addr_r <= CMD_ADDR;
      offs_r <= CMD_OFFS;
      wdata_r <= CMD_WDATA;
    end
  end

  // Completion
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      done_r <= 1'b0;
      fail_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      done_r <= finish;
      fail_r <= finish ? LK.nak : fail_r;
      rdata_r <= finish ? LK.rdata : rdata_r;
    end
  end

  assign LK.req = req_r;
  assign LK.wr = wr_r;
  assign LK.space = space_r;
  assign LK.addr = addr_r;
  assign LK.offs = offs_r;
  assign LK.wdata = wdata_r;
  assign CMD_BUSY = state_r == HS_WAIT;
  assign CMD_DONE = done_r;
  assign CMD_FAIL = fail_r;
  assign CMD_RDATA = rdata_r;
endmodule

// *** verilog/cod_link_if.sv ***
`timescale 1ns/1ns
interface cod_link_if;
  logic req;
  logic wr;
  logic [1:0] space;
  logic [15:0] addr;
  logic [4:0] offs;
  logic [7:0] wdata;
  logic ack;
  logic nak;
  logic [7:0] rdata;

  modport dev (input req, wr, space, addr, offs, wdata, output ack, nak, rdata);
  modport host (output req, wr, space, addr, offs, wdata, input ack, nak, rdata);
endinterface

// *** verilog/cod_pkg.sv ***
package cod_pkg;
  // Access paths carried on the link
  localparam logic [1:0] SP_REC = 2'h0;
  localparam logic [1:0] SP_IDX = 2'h1;
  localparam logic [1:0] SP_SUB = 2'h2;

  // Record numbers, object indices and subindices
  localparam logic [15:0] REC_HEAD = 16'h0000;
  localparam logic [15:0] REC_DIAG = 16'h0001;
  localparam logic [15:0] REC_FN0 = 16'h0080;
  localparam logic [15:0] REC_FN3 = 16'h0083;
  localparam logic [15:0] OI_PAR0 = 16'h3100;
  localparam logic [15:0] OI_PAR_LAST = 16'h3105;
  localparam logic [15:0] OI_DIAG_HEAD = 16'h2F00;
  localparam logic [15:0] OI_DIAG = 16'h2F01;
  localparam logic [15:0] OS_PAR0 = 16'h0001;
  localparam logic [15:0] OS_PAR_LAST = 16'h0006;

  // Parameter record byte positions
  localparam logic [2:0] PAR_RSVD = 3'h0;
  localparam logic [2:0] PAR_WBE = 3'h1;
  localparam logic [2:0] PAR_FN0 = 3'h2;
  localparam logic [4:0] PAR_REC0_LEN = 5'h02;

  // Reset values and range function numbers
  localparam logic [3:0] WBE_RST = 4'h0;
  localparam logic [7:0] FN_020_A = 8'h31;
  localparam logic [7:0] FN_020_B = 8'h41;
  localparam logic [7:0] FN_420_A = 8'h30;
  localparam logic [7:0] FN_420_B = 8'h40;
  localparam logic [7:0] FN_OFF = 8'hFF;
  localparam logic [7:0] FN_RST = FN_020_A;

  // Code scales and microamp spans
  localparam int SCALE_A = 27648;
  localparam int SCALE_B = 16384;
  localparam int OVR_A = 32511;
  localparam int OVR_B = 20480;
  localparam int UND_A = -6912;
  localparam int UND_B = -4096;
  localparam int UA_SPAN20 = 20000;
  localparam int UA_SPAN16 = 16000;
  localparam int UA_LIVE_ZERO = 4000;

  // Diagnostic record layout
  localparam logic [4:0] DIAG_HEAD = 5'h04;
  localparam logic [4:0] DIAG_BYTES = 5'h14;
  localparam logic [4:0] DG_MODFLAG = 5'h00;
  localparam logic [4:0] DG_MODINFO = 5'h01;
  localparam logic [4:0] DG_RSVD = 5'h02;
  localparam logic [4:0] DG_INTFLAG = 5'h03;
  localparam logic [4:0] DG_CHKIND = 5'h04;
  localparam logic [4:0] DG_NBITS = 5'h05;
  localparam logic [4:0] DG_NCH = 5'h06;
  localparam logic [4:0] DG_CHSUM = 5'h07;
  localparam logic [4:0] DG_CH0 = 5'h08;
  localparam logic [4:0] DG_CH3 = 5'h0B;
  localparam logic [4:0] DG_TS0 = 5'h10;
  localparam logic [4:0] DG_TS3 = 5'h13;

  // Fixed description bytes
  localparam logic [7:0] MODINFO_VAL = 8'h15;
  localparam logic [7:0] CHKIND_VAL = 8'h73;
  localparam logic [7:0] NBITS_VAL = 8'h08;
  localparam logic [7:0] NCH_VAL = 8'h04;

  // Bit positions in diagnostic bytes
  localparam int EA_FAIL = 0;
  localparam int EA_INT = 1;
  localparam int EA_EXT = 2;
  localparam int EA_CHAN = 3;
  localparam int EA_AUX = 4;
  localparam int EA_PARAM = 7;
  localparam int ED_OVF = 3;
  localparam int ED_COMM = 4;
  localparam int CE_PARAM = 0;
  localparam int CE_WBRK = 4;

  // Microsecond prescaler at 50 MHz
  localparam int CLK_PERIOD_NS = 20;
  localparam int US_NS = 1000;
  localparam logic [5:0] US_CYC = 6'(US_NS / CLK_PERIOD_NS);

  // Host states
  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_WAIT = 2'b10
  } cod_hstate_t;
endpackage
